// >>> logic/sdac_echo_prio.sv
// echo-channel ones counter and collision detector
`timescale 1ns/1ps
`default_nettype none
module sdac_echo_prio
  import sdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  sdac_prio_if.prio p
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic coll_q, coll_d;

  always_comb begin
    cnt_d = cnt_q;
    coll_d = 1'b0;
    if (!p.active) begin
      cnt_d = '0;
    end else if (p.strobe) begin
      if (!p.echo_bit) begin
        cnt_d = '0;
      end else if (cnt_q != CNT_MAX) begin
        cnt_d = cnt_q + CNT_W'(1);
      end
      // sent one overwritten by a zero on the echo
      coll_d = p.tx_active && p.tx_bit && !p.echo_bit;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      coll_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      coll_q <= coll_d;
    end
  end

  assign p.ones_cnt = cnt_q;
  assign p.reached = (cnt_q >= p.threshold);
  assign p.collision = coll_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_zero_restart: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (p.active && p.strobe && !p.echo_bit) |=> (cnt_q == '0)
  ) else $error("echo zero did not restart count");

  chk_ones_step: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (p.active && p.strobe && p.echo_bit && cnt_q < CNT_MAX)
      |=> (cnt_q == $past(cnt_q) + CNT_W'(1))
  ) else $error("echo one did not advance count");

  chk_coll_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (p.active && p.strobe && p.tx_active && p.tx_bit && !p.echo_bit)
      |=> p.collision ##1 !p.collision
  ) else $error("collision not flagged for one cycle");

endmodule
`default_nettype wire

// >>> logic/sdac_top.sv
// d-channel access control: arbitration bus stop/go and s-bus priority
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sdac_top
  import sdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [REG_DW-1:0] reg_rdata_o,
  input wire logic frame_sync_i,
  input wire logic data_clk_i,
  input wire logic up_data_i,
  output logic dn_data_o,
  output logic dn_data_oe_o,
  input wire logic s_bit_clk_i,
  input wire logic s_echo_i,
  output logic s_dch_o,
  output logic aux_port_pin_five_o
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] meta_q, sync_q, prev_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {s_echo_i, s_bit_clk_i, up_data_i, data_clk_i,
                 frame_sync_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic dcl_rise, dcl_fall, fs_rise, sclk_rise, sclk_fall, up_bit;
  assign dcl_rise = sync_q[IDX_DCL] & ~prev_q[IDX_DCL];
  assign dcl_fall = ~sync_q[IDX_DCL] & prev_q[IDX_DCL];
  assign fs_rise = sync_q[IDX_FS] & ~prev_q[IDX_FS];
  assign sclk_rise = sync_q[IDX_SCLK] & ~prev_q[IDX_SCLK];
  assign sclk_fall = ~sync_q[IDX_SCLK] & prev_q[IDX_SCLK];
  assign up_bit = sync_q[IDX_UP];

  // ------------------------------------------------------------
  // echo priority counter
  // ------------------------------------------------------------
  sdac_prio_if p ();

  sdac_echo_prio u_prio (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .p(p.prio)
  );

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  sdac_state_t st_q, st_d;
  logic [POS_W-1:0] pos_q, pos_d;
  logic [3:0] cmd_q, cmd_d;
  logic sge_q, sge_d;
  logic class_low_q, class_low_d;
  logic lower_q, lower_d;
  logic bac_q, bac_d;
  logic [2:0] addr_q, addr_d;
  logic sg_q, sg_d;
  logic dn_data_q, dn_data_d;
  logic dn_oe_q, dn_oe_d;
  logic aux_q, aux_d;
  logic [1:0] d_hold_q, d_hold_d;
  logic [1:0] d_cnt_q, d_cnt_d;
  logic s_dch_q, s_dch_d;
  logic coll_seen_q, coll_seen_d;
  logic [REG_DW-1:0] rdata_q, rdata_d;
  logic mc_write, st_write;
  logic [3:0] wr_cmd;
  logic [POS_W-1:0] tba_idx;

  assign mc_write = reg_we_i && (reg_addr_i == REG_MODE_CMD);
  assign st_write = reg_we_i && (reg_addr_i == REG_STATUS);
  assign wr_cmd = reg_wdata_i[MC_CMD_LSB +: 4];
  assign tba_idx = pos_q - POS_TBA0;

  // base count 8 or 10, one more at the lower level
  assign p.threshold = (class_low_q ? CNT_CLASS2 : CNT_CLASS1)
                       + (lower_q ? CNT_LOWER_STEP : '0);
  assign p.active = (st_q != ST_OFF);
  assign p.strobe = sclk_fall;
  assign p.echo_bit = sync_q[IDX_ECHO];
  assign p.tx_bit = s_dch_q;
  assign p.tx_active = (st_q == ST_SEND);

  always_comb begin
    st_d = st_q;
    pos_d = pos_q;
    cmd_d = cmd_q;
    sge_d = sge_q;
    class_low_d = class_low_q;
    lower_d = lower_q;
    bac_d = bac_q;
    addr_d = addr_q;
    dn_data_d = dn_data_q;
    dn_oe_d = dn_oe_q;
    d_hold_d = d_hold_q;
    d_cnt_d = d_cnt_q;
    s_dch_d = s_dch_q;
    coll_seen_d = coll_seen_q;
    rdata_d = '0;

    // frame position and the downstream stop/go slot
    if (dcl_rise) begin
      if (sync_q[IDX_FS]) begin
        pos_d = '0;
      end else if (pos_q != POS_LAST) begin
        pos_d = pos_q + POS_W'(1);
      end
      dn_oe_d = (st_q != ST_OFF) && (pos_d == POS_SG);
      dn_data_d = sg_q;
    end

    // upstream sampled on the falling edge, after wired-AND resolves
    if (dcl_fall) begin
      if (pos_q == POS_BAC) begin
        bac_d = up_bit;
      end
      if (pos_q >= POS_TBA0 && pos_q <= POS_TBA2) begin
        addr_d[tba_idx[1:0]] = up_bit;
      end
      if (pos_q == POS_D0) begin
        d_hold_d[1] = up_bit;
      end
      if (pos_q == POS_D1) begin
        d_hold_d[0] = up_bit;
        d_cnt_d = 2'h2;
      end
    end

    // frame-end evaluation of the arbitration outcome
    if (fs_rise) begin
      unique case (st_q)
        ST_MONITOR: begin
          // the echo run may have broken since go was last sent
          if (!bac_q && !sg_q && p.reached) begin
            st_d = ST_SEND;
          end
        end
        ST_SEND: begin
          if (bac_q) begin
            // winner released the bus: frame went out clean
            st_d = ST_MONITOR;
            lower_d = 1'b1;
          end
        end
        ST_OFF: begin
        end
      endcase
    end

    if (p.collision && st_q == ST_SEND) begin
      st_d = ST_MONITOR;
    end
    if (p.collision) begin
      coll_seen_d = 1'b1;
    end else if (st_write && reg_wdata_i[ST_COLL_BIT]) begin
      coll_seen_d = 1'b0;
    end

    // everyone has had a turn once the longer run is seen
    if (lower_q && st_q == ST_MONITOR && p.reached) begin
      lower_d = 1'b0;
    end

    // s-bus transmit: ones unless a granted frame is flowing
    if (st_d != ST_SEND) begin
      s_dch_d = 1'b1;
    end else if (sclk_rise) begin
      if (d_cnt_q != 2'h0) begin
        s_dch_d = d_hold_q[1];
        d_hold_d = {d_hold_q[0], 1'b1};
        d_cnt_d = d_cnt_q - 2'h1;
      end else begin
        // starved of data: ones cannot corrupt a flag boundary
        s_dch_d = 1'b1;
      end
    end

    if (mc_write) begin
      cmd_d = wr_cmd;
      sge_d = reg_wdata_i[MC_SGE_BIT];
      if (wr_cmd == CMD_AR_HIGH) begin
        class_low_d = 1'b0;
        if (st_q == ST_OFF) begin
          st_d = ST_MONITOR;
        end
      end else if (wr_cmd == CMD_AR_LOW) begin
        class_low_d = 1'b1;
        if (st_q == ST_OFF) begin
          st_d = ST_MONITOR;
        end
      end else begin
        st_d = ST_OFF;
        lower_d = 1'b0;
      end
    end

    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_MODE_CMD: rdata_d = {11'h000, sge_q, cmd_q};
        REG_STATUS: rdata_d = {3'h0, addr_q, bac_q, coll_seen_q,
                               st_q == ST_SEND, lower_q, class_low_q,
                               sg_q, p.ones_cnt};
        default: rdata_d = '0;
      endcase
    end
  end

  // stop unless sending, or monitoring with the echo run at the threshold and no collision
  always_comb begin
    sg_d = !((st_d == ST_SEND) ||
             (st_d == ST_MONITOR && p.reached && !p.collision));
    aux_d = sge_q ? sg_q : 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_OFF;
      pos_q <= '0;
      cmd_q <= CMD_RESET;
      sge_q <= 1'b0;
      class_low_q <= 1'b0;
      lower_q <= 1'b0;
      bac_q <= 1'b1;
      addr_q <= 3'h7;
      sg_q <= 1'b1;
      dn_data_q <= 1'b1;
      dn_oe_q <= 1'b0;
      aux_q <= 1'b0;
      d_hold_q <= 2'h3;
      d_cnt_q <= 2'h0;
      s_dch_q <= 1'b1;
      coll_seen_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      pos_q <= pos_d;
      cmd_q <= cmd_d;
      sge_q <= sge_d;
      class_low_q <= class_low_d;
      lower_q <= lower_d;
      bac_q <= bac_d;
      addr_q <= addr_d;
      sg_q <= sg_d;
      dn_data_q <= dn_data_d;
      dn_oe_q <= dn_oe_d;
      aux_q <= aux_d;
      d_hold_q <= d_hold_d;
      d_cnt_q <= d_cnt_d;
      s_dch_q <= s_dch_d;
      coll_seen_q <= coll_seen_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign dn_data_o = dn_data_q;
  assign dn_data_oe_o = dn_oe_q;
  assign s_dch_o = s_dch_q;
  assign aux_port_pin_five_o = aux_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_sg_needs_count: assert property (
    (st_q == ST_MONITOR && !p.reached && !mc_write) |=> sg_q
  ) else $error("go issued before echo threshold");

  chk_sg_base_eight: assert property (
    (st_q == ST_MONITOR && p.ones_cnt < CNT_CLASS1) |=> sg_q
  ) else $error("go issued below eight echo ones");

  chk_sg_after_coll: assert property (
    (p.collision && !mc_write) |=> sg_q [*2]
  ) else $error("stop not held after collision");

  chk_coll_stops: assert property (
    (p.collision && st_q == ST_SEND && !mc_write)
      |=> (st_q == ST_MONITOR) ##1 s_dch_q
  ) else $error("collision did not end sending");

  chk_idle_ones: assert property (
    (st_q != ST_SEND) |-> s_dch_q
  ) else $error("non-sending terminal drove a zero");

  chk_aux_follow: assert property (
    sge_q |=> (aux_q == $past(sg_q))
  ) else $error("aux pin does not follow stop/go");

  chk_sg_slot: assert property (
    $rose(dn_oe_q) |-> (pos_q == POS_SG && dn_data_q == $past(sg_q))
  ) else $error("stop/go driven outside its slot");

  chk_class_sel: assert property (
    (mc_write && wr_cmd == CMD_AR_LOW) |=> (class_low_q && st_q != ST_OFF)
  ) else $error("low class command not applied");

  chk_level_drop: assert property (
    (st_q == ST_SEND && fs_rise && bac_q && !p.collision && !mc_write)
      |=> lower_q
  ) else $error("successful frame did not lower level");

  cov_send: cover property ($rose(st_q == ST_SEND));
  cov_collision: cover property (p.collision && st_q == ST_SEND);
  cov_lower_go: cover property ($past(lower_q) && $fell(sg_q));

endmodule
`default_nettype wire

// >>> shared/sdac_pkg.sv
// constants and types shared by the d-channel access control block
package sdac_pkg;

  // ------------------------------------------------------------
  // frame interface layout (bit positions after frame sync)
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 96;
  localparam int POS_W = 7;
  localparam logic [POS_W-1:0] POS_LAST = 7'h5F;
  localparam logic [POS_W-1:0] POS_D0 = 7'h18;
  localparam logic [POS_W-1:0] POS_D1 = 7'h19;
  localparam logic [POS_W-1:0] POS_BAC = 7'h5A;
  localparam logic [POS_W-1:0] POS_TBA0 = 7'h5B;
  localparam logic [POS_W-1:0] POS_TBA2 = 7'h5D;
  localparam logic [POS_W-1:0] POS_SG = 7'h5A;

  // ------------------------------------------------------------
  // pin synchroniser lanes
  // ------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int IDX_FS = 0;
  localparam int IDX_DCL = 1;
  localparam int IDX_UP = 2;
  localparam int IDX_SCLK = 3;
  localparam int IDX_ECHO = 4;

  // ------------------------------------------------------------
  // echo-ones thresholds
  // ------------------------------------------------------------
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_CLASS1 = 4'h8;
  localparam logic [CNT_W-1:0] CNT_CLASS2 = 4'hA;
  localparam logic [CNT_W-1:0] CNT_LOWER_STEP = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;

  // ------------------------------------------------------------
  // command codes and register map
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_AR_HIGH = 4'h8;
  localparam logic [3:0] CMD_AR_LOW = 4'h9;
  localparam int REG_AW = 2;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] REG_MODE_CMD = 2'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 2'h1;
  localparam int MC_CMD_LSB = 0;
  localparam int MC_SGE_BIT = 4;
  localparam int ST_COLL_BIT = 8;
  localparam logic [3:0] CMD_RESET = 4'hF;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_MONITOR = 3'b010,
    ST_SEND = 3'b100
  } sdac_state_t;

endpackage

// >>> shared/sdac_prio_if.sv
// carrier between the access controller and the echo priority counter
`timescale 1ns/1ps
`default_nettype none
interface sdac_prio_if;
  import sdac_pkg::*;
  logic strobe;
  logic echo_bit;
  logic tx_bit;
  logic tx_active;
  logic active;
  logic [CNT_W-1:0] threshold;
  logic [CNT_W-1:0] ones_cnt;
  logic reached;
  logic collision;

  modport ctrl (
    output strobe, echo_bit, tx_bit, tx_active, active, threshold,
    input ones_cnt, reached, collision
  );
  modport prio (
    input strobe, echo_bit, tx_bit, tx_active, active, threshold,
    output ones_cnt, reached, collision
  );
endinterface
`default_nettype wire

// >>> test/sdac_hdlc_model.sv
// frame-bus partner: bit clock, frame sync, two contending controllers
`timescale 1ns/1ps
`default_nettype none
module sdac_hdlc_model
  import sdac_pkg::*;
(
  input wire logic [2:0] addr_a_i,
  input wire logic [2:0] addr_b_i,
  input wire logic req_i,
  output logic data_clk_o,
  output logic frame_sync_o,
  output logic up_data_o
);
  int pos;
  logic [2:0] ad [2];
  logic [1:0] want;
  logic hold;
  logic skip;
  initial begin
    data_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    up_data_o = 1'b1;
    pos = 0;
    want = 2'h0;
    hold = 1'b0;
    skip = 1'b0;
    // odd offset keeps the bit clock out of phase with the system clock
    #7;
    forever begin
      ad[0] = addr_a_i;
      ad[1] = addr_b_i;
      frame_sync_o = (pos == 0);
      // released line floats to its pull-up; d data are all ones
      up_data_o = 1'b1;
      if (pos == POS_BAC)
        up_data_o = ~hold;
      for (int k = 0; k < 3; k++)
        for (int i = 0; i < 2; i++)
          if (pos == POS_TBA0 + k && want[i] && !ad[i][k])
            up_data_o = 1'b0;
      data_clk_o = 1'b1;
      #100;
      data_clk_o = 1'b0;
      if (pos == POS_BAC) begin
        // the winner keeps its address on the bus while it holds access
        if (!hold)
          want = {2{req_i && up_data_o && !skip}};
        skip = 1'b0;
      end
      for (int i = 0; i < 2; i++)
        if (pos >= POS_TBA0 && pos <= POS_TBA2
            && ad[i][pos - POS_TBA0] !== up_data_o)
          want[i] = 1'b0;
      if (pos == POS_TBA2 && want != 2'h0)
        hold = 1'b1;
      if (pos == POS_LAST && hold && !req_i) begin
        hold = 1'b0;
        skip = 1'b1;
      end
      #100;
      pos = (pos + 1) % FRAME_BITS;
    end
  end
endmodule
`default_nettype wire

// >>> test/sdac_top_test.sv
// self-checking bench for the d-channel access control block
`timescale 1ns/1ps
`default_nettype none
module sdac_top_test;
  import sdac_pkg::*;
  logic clk, sys_rst, we, re, s_clk, s_echo, req;
  logic [REG_AW-1:0] addr;
  logic [REG_DW-1:0] wdata, rdata, rd_v;
  logic [2:0] ad_a, ad_b;
  wire fs, dclk, up, dn, dn_oe, s_dch, aux;
  int miscompares, compares, cnt, thr, r;
  logic cls, lower, send, coll;

  sdac_top dut (.clk_i(clk), .sys_rst_i(sys_rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .frame_sync_i(fs), .data_clk_i(dclk),
    .up_data_i(up), .dn_data_o(dn), .dn_data_oe_o(dn_oe),
    .s_bit_clk_i(s_clk), .s_echo_i(s_echo), .s_dch_o(s_dch),
    .aux_port_pin_five_o(aux));
  sdac_hdlc_model partner (.addr_a_i(ad_a), .addr_b_i(ad_b),
    .req_i(req), .data_clk_o(dclk), .frame_sync_o(fs), .up_data_o(up));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // reference model and compares
  // ------------------------------------------------------------
  function automatic logic [15:0] model_st();
    logic sg;
    sg = cnt < thr + lower;
    return {7'h0, coll, send, lower, cls, sg, cnt[3:0]};
  endfunction

  function automatic logic [2:0] resolve(input logic [2:0] a,
                                         input logic [2:0] b);
    logic [2:0] w;
    logic ia, ib;
    ia = 1'b1;
    ib = 1'b1;
    for (int k = 0; k < 3; k++) begin
      w[k] = (a[k] | !ia) & (b[k] | !ib);
      ia = ia & (a[k] == w[k]);
      ib = ib & (b[k] == w[k]);
    end
    return w;
  endfunction

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({15'h0, got}, {15'h0, exp});
  endtask

  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus and line drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rd_v = rdata;
  endtask

  task automatic chk_st(input logic [15:0] mask);
    rd(REG_STATUS);
    chk_reg(rd_v & mask, model_st() & mask);
  endtask

  // echo is the wired-and of our d bit and the other terminals' bit
  task automatic sbit(input logic other);
    @(posedge clk);
    s_clk <= 1'b1;
    repeat (6) @(posedge clk);
    s_echo <= s_dch & other;
    repeat (2) @(posedge clk);
    s_clk <= 1'b0;
    repeat (8) @(posedge clk);
    if (!other && send) begin
      coll = 1'b1;
      send = 1'b0;
    end
    cnt = other ? (cnt < 15 ? cnt + 1 : 15) : 0;
    if (lower && !send && cnt >= thr + 1)
      lower = 1'b0;
  endtask

  task automatic dn_check(input logic e);
    int n;
    n = 0;
    // skip a slot already under way: it carries an older stop/go
    while (dn_oe === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (dn_oe !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    #1 chk_pin(dn, e);
  endtask

  initial begin
    #1_000_000;
    miscompares++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {we, re, s_clk, req} = 4'h0;
    s_echo = 1'b1;
    addr = 2'h0;
    wdata = 16'h0;
    ad_a = 3'h0;
    ad_b = 3'h0;
    {miscompares, compares, cnt} = '0;
    thr = CNT_CLASS1;
    {cls, lower, send, coll} = 4'h0;
    r = $urandom(6);
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_MODE_CMD);
    chk_reg(rd_v, 16'h000F);
    wr(2'h2, 16'hFFFF);
    rd(2'h2);
    chk_reg(rd_v, 16'h0000);
    chk_st(16'h01FF);
    chk_pin(s_dch, 1'b1);
    r = 0;
    repeat (800) begin
      @(posedge clk);
      r += dn_oe;
    end
    chk_reg(r[15:0], 16'h0000);
    for (int c = 0; c < 2; c++) begin
      wr(REG_MODE_CMD, {12'h0, c ? CMD_AR_LOW : CMD_AR_HIGH});
      cls = c;
      thr = c ? CNT_CLASS2 : CNT_CLASS1;
      repeat ($urandom_range(thr - 1)) sbit(1'b1);
      sbit(1'b0);
      chk_st(16'h01FF);
      repeat (thr - 1) sbit(1'b1);
      chk_st(16'h01FF);
      sbit(1'b1);
      chk_st(16'h01FF);
    end
    repeat (6) sbit(1'b1);
    chk_st(16'h01FF);
    wr(REG_MODE_CMD, 16'h0018);
    cls = 1'b0;
    thr = CNT_CLASS1;
    repeat (4) @(posedge clk);
    chk_pin(aux, 1'b0);
    sbit(1'b0);
    chk_pin(aux, 1'b1);
    dn_check(1'b1);
    repeat (8) sbit(1'b1);
    chk_pin(aux, 1'b0);
    dn_check(1'b0);
    ad_a <= 3'($urandom_range(7));
    ad_b <= 3'($urandom_range(7));
    req <= 1'b1;
    repeat (4) @(posedge fs);
    send = 1'b1;
    rd(REG_STATUS);
    chk_reg(rd_v & 16'h1F80, {3'h0, resolve(ad_a, ad_b), 10'h080});
    sbit(1'b0);
    chk_pin(s_dch, 1'b1);
    chk_st(16'h01FF);
    wr(REG_STATUS, 16'h0100);
    coll = 1'b0;
    chk_st(16'h01FF);
    repeat (8) sbit(1'b1);
    repeat (2) @(posedge fs);
    send = 1'b1;
    chk_st(16'h01E0);
    req <= 1'b0;
    repeat (3) @(posedge fs);
    send = 1'b0;
    lower = 1'b1;
    chk_st(16'h01FF);
    sbit(1'b1);
    chk_st(16'h01FF);
    wr(REG_MODE_CMD, {12'h0, CMD_RESET});
    cnt = 0;
    chk_st(16'h01FF);
    finish_test();
  end
endmodule
`default_nettype wire
